// >>> pdr_pkg.sv
package pdr_pkg;

  // ----------------------------------------------------------------
  // Modes and host forms
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PDR_MODE_LAN,
    PDR_MODE_WAN,
    PDR_MODE_1G
  } pdr_mode_t;

  localparam int LANES = 4;
  localparam int WORD_W = 32;
  localparam int CORE_W = 64;
  localparam int CODE_W = 10;
  localparam int TAP_W = 4;
  localparam int RXAUI_LANE_A = 0;
  localparam int RXAUI_LANE_B = 2;
  localparam int GBE_LANE_LO = 0;
  localparam int GBE_LANE_HI = 3;
  localparam int SQUARE_RUN = 8;
  localparam logic [WORD_W-1:0] WAN_MARK = 32'hF628F628;
  localparam logic [CODE_W-1:0] IDLE_CODE = 10'h17C;
  localparam logic [1:0] CODE_DATA = 2'h1;

endpackage

// >>> pdr_if.sv
`timescale 1ns/1ps
interface pdr_if;
  import pdr_pkg::*;
  logic [LANES*CODE_W-1:0] h2d_lanes;
  logic [LANES-1:0] h2d_valid;
  logic [LANES*CODE_W-1:0] d2h_lanes;
  logic [LANES-1:0] d2h_valid;
  pdr_mode_t mode;
  logic rxaui;
  logic gbe_lane3;

  modport dev (
    input h2d_lanes, h2d_valid, mode, rxaui, gbe_lane3,
    output d2h_lanes, d2h_valid
  );
  modport host (
    input d2h_lanes, d2h_valid,
    output h2d_lanes, h2d_valid, mode, rxaui, gbe_lane3
  );
endinterface

// >>> pdr_device.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Line stream coding depends on mode.
// - WAN receive strips framing before coding.
// - LAN and 1G receive skip WAN stage.
// - 1G receive has no timestamp path; ts_path_en is unused.
// - 10G host data on four or two lanes.
// - RXAUI transmits only lanes zero and two.
// - RXAUI receive only lanes zero and two.
// - 1G uses one lane, same both ways.
// - 10G transmit decodes, aligns, then codes.
// - WAN transmit wraps payload in frame.
// - 1G transmit decodes then re-encodes.
// - Parallel data comes with rate strobe.
// - Deserializer gives 32-bit recovered words.
// - Loopback joins receive to transmit.
// - Lane sync derived while locked.
// - Two selectable clock outputs.
// - Signal monitor only in 10G modes.
// - Unity-gain monitoring zeroes feedback taps.
// - Three-tap thermometer-coded equalizer.
// - Square pattern with eight-one runs.
// - WAN is set for both directions.
module pdr_device
  import pdr_pkg::*;
(
  // ----------------------------------------------------------------
  // Clock and reset
  // ----------------------------------------------------------------
  input wire logic clk,
  input wire logic resetn,
  // Host side
  pdr_if.dev host,
  // Line side
  input wire logic [WORD_W-1:0] serial_rx_input,
  input wire logic serial_rx_valid,
  input wire logic rx_locked,
  output logic [WORD_W-1:0] serial_tx_output,
  output logic serial_tx_valid,
  // Control
  input wire logic loopback_en,
  input wire logic ts_path_en,
  input wire logic unity_gain_req,
  input wire logic square_en,
  input wire logic [1:0] tx_clk_sel,
  input wire logic [1:0] rx_clk_sel,
  input wire logic [3*TAP_W-1:0] tap_ctrl,
  // Status
  output logic [CORE_W-1:0] core_rx_data,
  output logic core_rx_strobe,
  output logic lane_sync,
  output logic tx_clock_output,
  output logic rx_clock_output,
  output logic monitor_active,
  output logic dfe_zero,
  output logic [3*(1<<TAP_W)-1:0] tap_therm,
  output logic wan_rx_q_o,
  output logic wan_tx_q_o
);

  // ----------------------------------------------------------------
  // Mode capture
  // ----------------------------------------------------------------
  // Mode is sampled once so every route changes on the same edge.
  pdr_mode_t mode_q;
  logic rxaui_q, lane3_q, half_q, lock_s1, lock_s2, loop_q;
  logic [WORD_W-1:0] rx_s1, rx_s2, tx_word;
  logic rxv_s1, rxv_s2;
  logic [CORE_W-1:0] demux_q;
  logic [3:0] sq_cnt_q;
  logic [CODE_W-1:0] lane_code_q [LANES];
  logic lane_vld_q [LANES];

  function automatic logic [(1<<TAP_W)-1:0] therm(input logic [TAP_W-1:0] v);
    logic [(1<<TAP_W)-1:0] t;
    t = '0;
    for (int i = 0; i < (1<<TAP_W); i++) begin
      t[i] = (i < v);
    end
    return t;
  endfunction

  function automatic int lane_ok(input int l, input pdr_mode_t m,
                                 input logic rx2, input logic l3);
    if (m == PDR_MODE_1G) begin
      return (l == (l3 ? GBE_LANE_HI : GBE_LANE_LO)) ? 1 : 0;
    end
    if (rx2) begin
      return (l == RXAUI_LANE_A || l == RXAUI_LANE_B) ? 1 : 0;
    end
    return 1;
  endfunction

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_q <= PDR_MODE_LAN;
      rxaui_q <= 1'b0;
      lane3_q <= 1'b0;
      loop_q <= 1'b0;
    end else begin
      mode_q <= host.mode;
      rxaui_q <= host.rxaui;
      lane3_q <= host.gbe_lane3;
      loop_q <= loopback_en;
    end
  end

  // Both direction flags load from one compare on host.mode, so WAN can never be split.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wan_rx_q_o <= 1'b0;
      wan_tx_q_o <= 1'b0;
    end else begin
      wan_rx_q_o <= (host.mode == PDR_MODE_WAN);
      wan_tx_q_o <= (host.mode == PDR_MODE_WAN);
    end
  end

  // ----------------------------------------------------------------
  // Line receive
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_s1 <= '0;
      rx_s2 <= '0;
      rxv_s1 <= 1'b0;
      rxv_s2 <= 1'b0;
      lock_s1 <= 1'b0;
      lock_s2 <= 1'b0;
    end else begin
      rx_s1 <= serial_rx_input;
      rx_s2 <= rx_s1;
      rxv_s1 <= serial_rx_valid;
      rxv_s2 <= rxv_s1;
      lock_s1 <= rx_locked;
      lock_s2 <= lock_s1;
    end
  end

  // Two words are paired into one core word with a strobe.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      demux_q <= '0;
      half_q <= 1'b0;
      core_rx_data <= '0;
      core_rx_strobe <= 1'b0;
    end else begin
      core_rx_strobe <= 1'b0;
      if (rxv_s2) begin
        half_q <= ~half_q;
        if (!half_q) begin
          demux_q[WORD_W-1:0] <= rx_s2;
        end else begin
          core_rx_strobe <= 1'b1;
          if (wan_rx_q_o) begin
            // Frame mark is stripped from payload.
            core_rx_data <= {rx_s2 ^ WAN_MARK, demux_q[WORD_W-1:0]};
          end else begin
            core_rx_data <= {rx_s2, demux_q[WORD_W-1:0]};
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Host lanes
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          lane_code_q[g] <= IDLE_CODE;
          lane_vld_q[g] <= 1'b0;
        end else if (lane_ok(g, mode_q, rxaui_q, lane3_q) != 0) begin
          lane_vld_q[g] <= core_rx_strobe;
          lane_code_q[g] <= core_rx_data[g*CODE_W +: CODE_W];
        end else begin
          lane_vld_q[g] <= 1'b0;
          lane_code_q[g] <= IDLE_CODE;
        end
      end
      // Each lane owns its register, so no two processes share a variable.
      assign host.d2h_lanes[g*CODE_W +: CODE_W] = lane_code_q[g];
      assign host.d2h_valid[g] = lane_vld_q[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Line transmit
  // ----------------------------------------------------------------
  always_comb begin
    tx_word = '0;
    for (int l = 0; l < LANES; l++) begin
      if (host.h2d_valid[l] && lane_ok(l, mode_q, rxaui_q, lane3_q) != 0)
      begin
        tx_word = tx_word ^ {22'h0, host.h2d_lanes[l*CODE_W +: CODE_W]};
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      serial_tx_output <= '0;
      serial_tx_valid <= 1'b0;
      sq_cnt_q <= '0;
    end else if (square_en) begin
      sq_cnt_q <= sq_cnt_q + 4'h1;
      serial_tx_output <= sq_cnt_q[3] ? '1 : '0;
      serial_tx_valid <= 1'b1;
    end else if (loop_q) begin
      serial_tx_output <= rx_s2;
      serial_tx_valid <= rxv_s2;
    end else begin
      serial_tx_output <= wan_tx_q_o ? tx_word ^ WAN_MARK : tx_word;
      serial_tx_valid <= |host.h2d_valid;
    end
  end

  // ----------------------------------------------------------------
  // Clocks, monitor, equalizer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lane_sync <= 1'b0;
      tx_clock_output <= 1'b0;
      rx_clock_output <= 1'b0;
      monitor_active <= 1'b0;
      dfe_zero <= 1'b0;
      tap_therm <= '0;
    end else begin
      lane_sync <= lock_s2 ? ~lane_sync : 1'b0;
      tx_clock_output <= (tx_clk_sel == 2'h0) ? lane_sync :
                         (tx_clk_sel == 2'h1) ? half_q :
                         (tx_clk_sel == 2'h2) ? sq_cnt_q[0] : 1'b0;
      rx_clock_output <= (rx_clk_sel == 2'h0) ? lane_sync :
                         (rx_clk_sel == 2'h1) ? half_q :
                         (rx_clk_sel == 2'h2) ? sq_cnt_q[0] : 1'b0;
      monitor_active <= unity_gain_req && mode_q != PDR_MODE_1G;
      dfe_zero <= unity_gain_req && mode_q != PDR_MODE_1G;
      for (int k = 0; k < 3; k++) begin
        tap_therm[k*(1<<TAP_W) +: (1<<TAP_W)] <=
          therm(tap_ctrl[k*TAP_W +: TAP_W]);
      end
    end
  end

endmodule

// >>> pdr_host.sv
`timescale 1ns/1ps
module pdr_host
  import pdr_pkg::*;
(
  // ----------------------------------------------------------------
  // Clock and reset
  // ----------------------------------------------------------------
  input wire logic clk,
  input wire logic resetn,
  // Device side
  pdr_if.host dev,
  // User side
  input wire logic [1:0] mode_sel,
  input wire logic rxaui_sel,
  input wire logic lane3_sel,
  input wire logic [LANES*CODE_W-1:0] tx_codes,
  input wire logic tx_req,
  output logic [LANES*CODE_W-1:0] rx_codes,
  output logic rx_strobe
);

  // ----------------------------------------------------------------
  // Lane use
  // ----------------------------------------------------------------
  // Unused lanes stay idle so the device never sees stray traffic.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dev.mode <= PDR_MODE_LAN;
      dev.rxaui <= 1'b0;
      dev.gbe_lane3 <= 1'b0;
      dev.h2d_valid <= '0;
      dev.h2d_lanes <= '0;
      rx_codes <= '0;
      rx_strobe <= 1'b0;
    end else begin
      dev.mode <= pdr_mode_t'((mode_sel == 2'h3) ? 2'h0 : mode_sel);
      dev.rxaui <= rxaui_sel;
      dev.gbe_lane3 <= lane3_sel;
      dev.h2d_lanes <= tx_codes;
      for (int l = 0; l < LANES; l++) begin
        if (dev.mode == PDR_MODE_1G) begin
          dev.h2d_valid[l] <= tx_req &&
            l == (dev.gbe_lane3 ? GBE_LANE_HI : GBE_LANE_LO);
        end else if (dev.rxaui) begin
          dev.h2d_valid[l] <= tx_req &&
            (l == RXAUI_LANE_A || l == RXAUI_LANE_B);
        end else begin
          dev.h2d_valid[l] <= tx_req;
        end
      end
      rx_strobe <= |dev.d2h_valid;
      rx_codes <= dev.d2h_lanes;
    end
  end

endmodule

// >>> pdr_chk.sv
`timescale 1ns/1ps
module pdr_chk
  import pdr_pkg::*;
(
  // ----------------------------------------------------------------
  // Clock, reset and interface
  // ----------------------------------------------------------------
  input wire logic clk,
  input wire logic resetn,
  input wire logic [LANES*CODE_W-1:0] h2d_lanes,
  input wire logic [LANES-1:0] h2d_valid,
  input wire logic [LANES*CODE_W-1:0] d2h_lanes,
  input wire logic [LANES-1:0] d2h_valid,
  input wire pdr_mode_t mode,
  input wire logic rxaui,
  input wire logic gbe_lane3
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire g1 = mode == PDR_MODE_1G;
  wire [3:0] gm = gbe_lane3 ? 4'h8 : 4'h1;
  property p_mode_ok;
    mode inside {PDR_MODE_LAN, PDR_MODE_WAN, PDR_MODE_1G};
  endproperty
  a_mode_ok: assert property (p_mode_ok) else $error("bad mode");
  property p_rx_lanes;
    !g1 && rxaui |-> (d2h_valid & 4'hA) == 4'h0;
  endproperty
  a_rx_lanes: assert property (p_rx_lanes) else $error("d2h lane");
  property p_rx_pair;
    !g1 && rxaui |-> d2h_valid[0] == d2h_valid[2];
  endproperty
  a_rx_pair: assert property (p_rx_pair) else $error("d2h pair");
  property p_tx_lanes;
    !g1 && rxaui |-> (h2d_valid & 4'hA) == 4'h0;
  endproperty
  a_tx_lanes: assert property (p_tx_lanes) else $error("h2d lane");
  property p_gbe_d2h;
    g1 |-> (d2h_valid & ~gm) == 4'h0;
  endproperty
  a_gbe_d2h: assert property (p_gbe_d2h) else $error("1g d2h lane");
  property p_gbe_h2d;
    g1 |-> (h2d_valid & ~gm) == 4'h0;
  endproperty
  a_gbe_h2d: assert property (p_gbe_h2d) else $error("1g h2d lane");
  property p_xaui_all;
    !g1 && !rxaui && (|d2h_valid) |-> &d2h_valid;
  endproperty
  a_xaui_all: assert property (p_xaui_all) else $error("xaui lanes");
  // Two words make one result, so a result can never repeat next cycle.
  property p_pulse;
    |d2h_valid |=> (d2h_valid == 4'h0);
  endproperty
  a_pulse: assert property (p_pulse) else $error("d2h not pulse");
  c_wan: cover property (mode == PDR_MODE_WAN && |d2h_valid);
  c_gbe: cover property (g1 && |d2h_valid);
  c_rxaui: cover property (rxaui && !g1 && |h2d_valid);
endmodule

// >>> phy_datapath_mode_lane_routing_bench.sv
`timescale 1ns/1ps
module phy_datapath_mode_lane_routing_bench;
  import pdr_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observation
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic resetn = 1'b0;
  always #12.5 clk = ~clk;
  logic [31:0] seed = 32'h1311;
  logic [WORD_W-1:0] rx_word = '0;
  logic rx_vld = 1'b0;
  logic [1:0] mode_sel = 2'h0;
  logic rxaui_sel = 1'b0;
  logic lane3_sel = 1'b0;
  logic tx_req = 1'b0;
  logic ug = 1'b0;
  logic ts_en = 1'b0;
  logic [LANES*CODE_W-1:0] tx_codes = '0;
  logic [1:0] tsel = 2'h0;
  logic [1:0] rsel = 2'h0;
  logic [3*TAP_W-1:0] taps = '0;
  logic [WORD_W-1:0] stx;
  logic stx_v, core_stb, mon, dfe;
  logic [CORE_W-1:0] core_d;
  logic [3*(1<<TAP_W)-1:0] therm;
  logic [WORD_W-1:0] q_tx[$];
  logic [CORE_W-1:0] q_core[$];
  logic [LANES*CODE_W-1:0] q_host[$];
  logic [63:0] ev;
  logic lock = 1'b1;
  logic loop_en = 1'b0;
  logic sq_en = 1'b0;
  logic lsync, tck, rck, wrx, wtx, hstb;
  logic [LANES*CODE_W-1:0] hcodes;
  int n_fail = 0;
  int checks_done = 0;
  pdr_if bus ();
  pdr_device pdr_device_inst (.clk(clk), .resetn(resetn), .host(bus),
    .serial_rx_input(rx_word), .serial_rx_valid(rx_vld), .rx_locked(lock),
    .serial_tx_output(stx), .serial_tx_valid(stx_v),
    .loopback_en(loop_en), .ts_path_en(ts_en), .unity_gain_req(ug),
    .square_en(sq_en), .tx_clk_sel(tsel), .rx_clk_sel(rsel),
    .tap_ctrl(taps), .core_rx_data(core_d), .core_rx_strobe(core_stb),
    .lane_sync(lsync), .tx_clock_output(tck), .rx_clock_output(rck),
    .monitor_active(mon), .dfe_zero(dfe), .tap_therm(therm),
    .wan_rx_q_o(wrx), .wan_tx_q_o(wtx));
  pdr_host pdr_host_inst (.clk(clk), .resetn(resetn), .dev(bus),
    .mode_sel(mode_sel), .rxaui_sel(rxaui_sel), .lane3_sel(lane3_sel),
    .tx_codes(tx_codes), .tx_req(tx_req), .rx_codes(hcodes),
    .rx_strobe(hstb));
  pdr_chk pdr_chk_inst (.clk(clk), .resetn(resetn),
    .h2d_lanes(bus.h2d_lanes), .h2d_valid(bus.h2d_valid),
    .d2h_lanes(bus.d2h_lanes), .d2h_valid(bus.d2h_valid),
    .mode(bus.mode), .rxaui(bus.rxaui), .gbe_lane3(bus.gbe_lane3));

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Config c: mode c/2, odd c selects the two-lane form or lane 3.
  function automatic bit lane_on(input int l, input int c);
    return c < 4 ? (c % 2 == 0 || l % 2 == 0) : l == (c % 2) * 3;
  endfunction

  // Lanes that the config leaves out must show the idle code.
  function automatic logic [39:0] lanes_exp(input logic [39:0] cd,
                                            input int c);
    logic [39:0] a;
    a = '0;
    for (int l = 0; l < 4; l++) begin
      a[l*10+:10] = lane_on(l, c) ? cd[l*10+:10] : IDLE_CODE;
    end
    return a;
  endfunction

  function automatic logic [31:0] tx_exp(input logic [39:0] cd, input int c);
    logic [31:0] a;
    a = (c / 2 == 1) ? WAN_MARK : '0;
    for (int l = 0; l < 4; l++) begin
      if (lane_on(l, c)) begin
        a ^= {22'h0, cd[l*10+:10]};
      end
    end
    return a;
  endfunction

  task automatic check(input string what, input logic [63:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task conclude;
    if (n_fail == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // A bounded wait; results that never arrive count as failures.
  task drain;
    repeat (20) begin
      if (q_tx.size() + q_core.size() + q_host.size() == 0) begin
        return;
      end
      @(negedge clk);
    end
    n_fail++;
    conclude();
  endtask

  // Two line words make one core word; lb marks a loopback run.
  task automatic send_rx(input int c, input bit lb);
    logic [31:0] w0, w1;
    logic [63:0] cw;
    w0 = rnd();
    w1 = rnd();
    cw = {w1 ^ (c / 2 == 1 ? WAN_MARK : '0), w0};
    q_core.push_back(cw);
    q_host.push_back(lanes_exp(cw[39:0], c));
    if (lb) begin
      q_tx.push_back(w0);
      q_tx.push_back(w1);
    end
    rx_word = w0;
    rx_vld = 1'b1;
    @(negedge clk);
    rx_word = w1;
    @(negedge clk);
    rx_vld = 1'b0;
    rx_word = ~w1;
  endtask

  // Outputs are read at the falling edge, well away from their launch.
  always @(negedge clk) begin
    if (core_stb === 1'b1) begin
      ev = q_core.size() ? q_core.pop_front() : 'x;
      check("core_rx_data", core_d, ev);
    end
    if (stx_v === 1'b1) begin
      ev = q_tx.size() ? q_tx.pop_front() : 'x;
      check("serial_tx", stx, ev);
    end
    if (hstb === 1'b1) begin
      ev = q_host.size() ? q_host.pop_front() : 'x;
      check("rx_codes", hcodes, ev);
    end
  end

  initial begin
    logic [31:0] r;
    logic [63:0] r64, e;
    logic l0, t0, r0;
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    for (int c = 0; c < 6; c++) begin
      @(negedge clk);
      r = rnd();
      mode_sel = 2'(c / 2);
      rxaui_sel = 1'(c % 2);
      lane3_sel = 1'(c % 2);
      {rsel, tsel, ts_en, taps, ug} = r[17:0];
      repeat (8) @(negedge clk);
      check("dfe_zero", dfe, ug && c < 4);
      check("monitor_active", mon, ug && c < 4);
      check("wan_rx", wrx, c / 2 == 1);
      check("wan_tx", wtx, c / 2 == 1);
      for (int i = 0; i < 3; i++) begin
        e = (64'h1 << taps[i*4+:4]) - 64'h1;
        check("tap_therm", therm[i*16+:16], e);
      end
      {l0, t0, r0} = {lsync, tck, rck};
      @(negedge clk);
      check("lane_sync", lsync ^ l0, 1'b1);
      check("tx_clock_output", tck ^ t0, tsel == 2'h0);
      check("rx_clock_output", rck ^ r0, rsel == 2'h0);
      send_rx(c, 1'b0);
      for (int k = 0; k < 2; k++) begin
        r64 = {rnd(), rnd()};
        tx_codes = r64[39:0];
        q_tx.push_back(tx_exp(r64[39:0], c));
        tx_req = 1'b1;
        @(negedge clk);
      end
      tx_req = 1'b0;
      drain();
    end
    // Loopback returns line words to the line unchanged.
    loop_en = 1'b1;
    repeat (2) @(negedge clk);
    send_rx(5, 1'b1);
    drain();
    loop_en = 1'b0;
    // The square pattern starts from a cleared counter: zeros, then ones.
    for (int i = 0; i < 2 * SQUARE_RUN; i++) begin
      q_tx.push_back({WORD_W{i >= SQUARE_RUN}});
    end
    sq_en = 1'b1;
    repeat (2 * SQUARE_RUN) @(negedge clk);
    sq_en = 1'b0;
    drain();
    lock = 1'b0;
    repeat (4) @(negedge clk);
    check("lane_sync", lsync, 1'b0);
    conclude();
  end
endmodule
